// ==== rtl/asw_top.sv ====
`timescale 1ns/1ps
// How it works
// RL1: Redirect clear: writing one to sleep enable starts the sleep sequence.
// RL2: Redirect set: sleep enable write raises SMI instead of sleeping.
// RL3: Every sleep enable write sets the SMI flag; redirect gates it.
// RL4: Source select clear: wake status set only by power-on request fall.
// RL5: Source select set: enabled wake events also set wake status.
// RL6: PLL power bit zero keeps the 32 kHz PLL unpowered.
// RL7: PLL power bit one runs PLL, usable as infrared wakeup clock.
// RL8: Reserved configuration bits two to six read zero, writes ignored.
module asw_top (
	input  wire logic              CLK_SYS_IN,
	input  wire logic              RST_N_IN,
	input  wire logic [7:0]        S_AXI_AWADDR_IN,
	input  wire logic              S_AXI_AWVALID_IN,
	output logic                   S_AXI_AWREADY_OUT,
	input  wire logic [31:0]       S_AXI_WDATA_IN,
	input  wire logic [3:0]        S_AXI_WSTRB_IN,
	input  wire logic              S_AXI_WVALID_IN,
	output logic                   S_AXI_WREADY_OUT,
	output logic [1:0]             S_AXI_BRESP_OUT,
	output logic                   S_AXI_BVALID_OUT,
	input  wire logic              S_AXI_BREADY_IN,
	input  wire logic [7:0]        S_AXI_ARADDR_IN,
	input  wire logic              S_AXI_ARVALID_IN,
	output logic                   S_AXI_ARREADY_OUT,
	output logic [31:0]            S_AXI_RDATA_OUT,
	output logic [1:0]             S_AXI_RRESP_OUT,
	output logic                   S_AXI_RVALID_OUT,
	input  wire logic              S_AXI_RREADY_IN,
	input  wire logic              POWER_ON_REQUEST_N_IN,
	input  wire logic [7:0]        WAKE_EVENT_IN,
	input  wire logic              SLEEP_DONE_IN,
	output logic                   SLEEP_REQ_OUT,
	output logic [2:0]             SLEEP_TYPE_OUT,
	output logic                   SMI_OUT,
	output logic                   WAKE_STATUS_OUT,
	output logic                   PLL_POWER_OUT,
	output logic                   IR_CLK_SEL_PLL_OUT
);

	asw_pkg::asw_cfg_t cfg_r;
	asw_pkg::asw_seq_t seq_r;
	logic [2:0]        slp_type_r;
	logic [7:0]        wake_en_r;
	logic              smi_flag_r;
	logic              wak_sts_r;
	logic [9:0]        sync1_r;
	logic [9:0]        sync2_r;
	logic [9:0]        prev_r;
	logic [7:0]        aw_addr_r;
	logic              aw_held_r;
	logic [31:0]       w_data_r;
	logic [3:0]        w_strb_r;
	logic              w_held_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;
	logic              wr_fire;
	logic              wr_lane0;
	logic              slp_write;
	logic              sts_write;
	logic              pwr_fall;
	logic [7:0]        ev_rise;
	logic              wake_set;
	logic              pwr_n_s;
	logic              done_s;
	logic [7:0]        ev_s;
	logic [31:0]       rd_word;
	logic              rd_hit;

	// Handshake outputs straight from holding state
	assign S_AXI_AWREADY_OUT = !aw_held_r && !bvalid_r;
	assign S_AXI_WREADY_OUT  = !w_held_r && !bvalid_r;
	assign S_AXI_ARREADY_OUT = !rvalid_r;
	assign S_AXI_BVALID_OUT  = bvalid_r;
	assign S_AXI_BRESP_OUT   = bresp_r;
	assign S_AXI_RVALID_OUT  = rvalid_r;
	assign S_AXI_RDATA_OUT   = rdata_r;
	assign S_AXI_RRESP_OUT   = rresp_r;

	// Commit once both address and data are held
	assign wr_fire   = aw_held_r && w_held_r && !bvalid_r;
	assign wr_lane0  = wr_fire && w_strb_r[0];
	assign slp_write = wr_lane0 && (aw_addr_r == asw_pkg::ADDR_CTRL) &&
		w_data_r[asw_pkg::CTRL_SLP_EN_BIT];
	assign sts_write = wr_lane0 && (aw_addr_r == asw_pkg::ADDR_STATUS);

	// Synchronised views of the pins
	assign pwr_n_s = sync2_r[9];
	assign done_s  = sync2_r[8];
	assign ev_s    = sync2_r[7:0];

	// Edge detection on synchronised levels only
	assign pwr_fall = prev_r[9] && !pwr_n_s;
	assign ev_rise  = ev_s & ~prev_r[7:0] & wake_en_r;
	assign wake_set = pwr_fall || // RL4
		(cfg_r.wake_status_source_select && (|ev_rise)); // RL5

	// Block outputs
	assign SLEEP_REQ_OUT      = (seq_r == asw_pkg::SEQ_ACTIVE);
	assign SLEEP_TYPE_OUT     = slp_type_r;
	assign SMI_OUT            = smi_flag_r && cfg_r.sleep_trigger_redirect; // RL2
	assign WAKE_STATUS_OUT    = wak_sts_r;
	assign PLL_POWER_OUT      = cfg_r.infrared_pll_power; // RL6
	assign IR_CLK_SEL_PLL_OUT = cfg_r.infrared_pll_power; // RL7

	// Two-stage synchroniser; request pin idles high
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sync1_r <= asw_pkg::SYNC_RESET;
			sync2_r <= asw_pkg::SYNC_RESET;
			prev_r  <= asw_pkg::SYNC_RESET;
		end else begin
			sync1_r <= {POWER_ON_REQUEST_N_IN, SLEEP_DONE_IN, WAKE_EVENT_IN};
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	// Write address and data captured in either order
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_held_r  <= 1'b0;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
		end else begin
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= S_AXI_AWADDR_IN;
			end else if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
				w_held_r <= 1'b1;
				w_data_r <= S_AXI_WDATA_IN;
				w_strb_r <= S_AXI_WSTRB_IN;
			end else if (wr_fire) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			bvalid_r <= 1'b0;
			bresp_r  <= asw_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			case (aw_addr_r)
				asw_pkg::ADDR_CTRL,
				asw_pkg::ADDR_STATUS,
				asw_pkg::ADDR_WAKE_EN,
				asw_pkg::ADDR_CFG: bresp_r <= asw_pkg::RESP_OKAY;
				default:           bresp_r <= asw_pkg::RESP_SLVERR;
			endcase
		end else if (bvalid_r && S_AXI_BREADY_IN) begin
			bvalid_r <= 1'b0;
		end
	end

	// Configuration and wake enable registers
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			cfg_r     <= asw_pkg::CFG_RESET;
			wake_en_r <= asw_pkg::WAKE_EN_RESET;
		end else if (wr_lane0) begin
			if (aw_addr_r == asw_pkg::ADDR_CFG) begin
				// Reserved bits never stored, so they read zero
				cfg_r <= w_data_r[7:0] & asw_pkg::CFG_WMASK; // RL8
			end
			if (aw_addr_r == asw_pkg::ADDR_WAKE_EN) begin
				wake_en_r <= w_data_r[7:0];
			end
		end
	end

	// Sleep type latched with every control register write with lane zero enabled while the sequencer is idle
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			slp_type_r <= asw_pkg::SLP_TYPE_RESET;
		end else if (wr_lane0 && aw_addr_r == asw_pkg::ADDR_CTRL &&
				seq_r == asw_pkg::SEQ_IDLE) begin
			slp_type_r <= w_data_r[asw_pkg::CTRL_TYPE_LSB +: asw_pkg::SLP_TYPE_W];
		end
	end

	// Sleep sequencer; a new request while busy is dropped
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			seq_r <= asw_pkg::SEQ_IDLE;
		end else begin
			unique case (seq_r)
				asw_pkg::SEQ_IDLE: begin
					if (slp_write && !cfg_r.sleep_trigger_redirect) begin
						seq_r <= asw_pkg::SEQ_ACTIVE; // RL1
					end
				end
				asw_pkg::SEQ_ACTIVE: begin
					if (done_s) begin
						seq_r <= asw_pkg::SEQ_IDLE;
					end
				end
				default: seq_r <= asw_pkg::SEQ_IDLE;
			endcase
		end
	end

	// Sticky flags, write one to clear; a new set beats the clear
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			smi_flag_r <= 1'b0;
			wak_sts_r  <= 1'b0;
		end else begin
			if (slp_write) begin
				smi_flag_r <= 1'b1; // RL3
			end else if (sts_write && w_data_r[asw_pkg::STS_SMI_BIT]) begin
				smi_flag_r <= 1'b0;
			end
			if (wake_set) begin
				wak_sts_r <= 1'b1;
			end else if (sts_write && w_data_r[asw_pkg::STS_WAK_BIT]) begin
				wak_sts_r <= 1'b0;
			end
		end
	end

	// Read mux
	always_comb begin
		rd_word = 32'h00000000;
		rd_hit  = 1'b1;
		case (S_AXI_ARADDR_IN)
			asw_pkg::ADDR_CTRL: begin
				rd_word[asw_pkg::CTRL_TYPE_LSB +: asw_pkg::SLP_TYPE_W] = slp_type_r;
			end
			asw_pkg::ADDR_STATUS: begin
				rd_word[asw_pkg::STS_SMI_BIT]  = smi_flag_r;
				rd_word[asw_pkg::STS_WAK_BIT]  = wak_sts_r;
				rd_word[asw_pkg::STS_BUSY_BIT] = (seq_r == asw_pkg::SEQ_ACTIVE);
			end
			asw_pkg::ADDR_WAKE_EN: rd_word[7:0] = wake_en_r;
			asw_pkg::ADDR_CFG:     rd_word[7:0] = cfg_r; // RL8
			default:               rd_hit = 1'b0;
		endcase
	end

	// Read data registered at the edge that takes the address
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= asw_pkg::RESP_OKAY;
		end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= rd_hit ? asw_pkg::RESP_OKAY : asw_pkg::RESP_SLVERR;
		end else if (rvalid_r && S_AXI_RREADY_IN) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule

// ==== include/asw_pkg.sv ====
package asw_pkg;

	// Register byte addresses on the AXI4-Lite bus
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_WAKE_EN = 8'h08;
	localparam logic [7:0] ADDR_CFG     = 8'hF0;

	// Sleep/wake configuration field positions and reset value
	localparam int         CFG_REDIRECT_BIT = 0;
	localparam int         CFG_WAKESEL_BIT  = 1;
	localparam int         CFG_PLL_BIT      = 7;
	localparam logic [7:0] CFG_WMASK        = 8'h83;
	localparam logic [7:0] CFG_RESET        = 8'h00;

	// Sleep control register fields
	localparam int         CTRL_SLP_EN_BIT  = 0;
	localparam int         CTRL_TYPE_LSB    = 1;
	localparam int         SLP_TYPE_W       = 3;
	localparam logic [2:0] SLP_TYPE_RESET   = 3'h0;

	// Status register fields
	localparam int         STS_SMI_BIT      = 0;
	localparam int         STS_WAK_BIT      = 1;
	localparam int         STS_BUSY_BIT     = 2;

	// Wakeup event sources and their enable reset value
	localparam int         WAKE_W           = 8;
	localparam logic [7:0] WAKE_EN_RESET    = 8'h00;

	// Synchroniser layout {power_on_request_n, sleep_done, events}
	localparam int          SYNC_W     = 10;
	localparam logic [9:0]  SYNC_RESET = 10'h200;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       infrared_pll_power;
		logic [4:0] rsvd;
		logic       wake_status_source_select;
		logic       sleep_trigger_redirect;
	} asw_cfg_t;

	typedef enum logic [1:0] {
		SEQ_IDLE   = 2'b01,
		SEQ_ACTIVE = 2'b10
	} asw_seq_t;

endpackage

// ==== testbench/asw_top_asserts.sv ====
`timescale 1ns/1ps
module asw_top_asserts (
	input wire logic        CLK_SYS_IN,
	input wire logic        RST_N_IN,
	input wire logic        S_AXI_AWREADY_OUT,
	input wire logic        S_AXI_WREADY_OUT,
	input wire logic [1:0]  S_AXI_BRESP_OUT,
	input wire logic        S_AXI_BVALID_OUT,
	input wire logic        S_AXI_BREADY_IN,
	input wire logic [7:0]  S_AXI_ARADDR_IN,
	input wire logic        S_AXI_ARVALID_IN,
	input wire logic        S_AXI_ARREADY_OUT,
	input wire logic [31:0] S_AXI_RDATA_OUT,
	input wire logic        S_AXI_RVALID_OUT,
	input wire logic        S_AXI_RREADY_IN,
	input wire logic        SLEEP_DONE_IN,
	input wire logic        SLEEP_REQ_OUT,
	input wire logic        SMI_OUT,
	input wire logic        PLL_POWER_OUT,
	input wire logic        IR_CLK_SEL_PLL_OUT
);
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_N_IN);
	// Done pin quiet long enough that no stale synced value remains
	sequence s_done_quiet;
		!SLEEP_DONE_IN [*6];
	endsequence
	sequence s_ar_take;
		S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
	endsequence
	// Configuration register read taken at this edge
	sequence s_cfg_take;
		s_ar_take ##0 (S_AXI_ARADDR_IN == asw_pkg::ADDR_CFG);
	endsequence
	// Write answer appears; all register effects land on this edge
	sequence s_b_start;
		$rose(S_AXI_BVALID_OUT);
	endsequence
	AST_SLP_HOLD: assert property (
		s_done_quiet ##0 SLEEP_REQ_OUT |=> SLEEP_REQ_OUT)
		else $error("sleep request dropped without done");
	AST_SLP_NO_SMI: assert property (
		$rose(SLEEP_REQ_OUT) |-> !SMI_OUT)
		else $error("sleep started while smi raised");
	AST_PLL: assert property (
		PLL_POWER_OUT == IR_CLK_SEL_PLL_OUT)
		else $error("infrared clock select differs from pll power");
	AST_PLL_WR: assert property (
		$changed(PLL_POWER_OUT) |-> s_b_start)
		else $error("pll power changed without a register write");
	AST_SMI_WR: assert property (
		$rose(SMI_OUT) |-> s_b_start)
		else $error("smi raised without a register write");
	AST_RSVD_RD: assert property (
		S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h000000)
		else $error("upper read data not zero");
	AST_RSVD_CFG: assert property (
		s_cfg_take |=> S_AXI_RDATA_OUT[6:2] == 5'h00)
		else $error("reserved configuration bits read nonzero");
	AST_AR_RESP: assert property (s_ar_take |=> S_AXI_RVALID_OUT)
		else $error("read answer late");
	AST_RV_HOLD: assert property (
		S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
		S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
		else $error("read answer not held");
	AST_BV_HOLD: assert property (
		S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
		S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
		else $error("write answer not held");
	AST_B_BLOCK: assert property (
		S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
		else $error("write accepted while answer pending");
endmodule
bind asw_top asw_top_asserts u_chk (.CLK_SYS_IN, .RST_N_IN, .S_AXI_AWREADY_OUT,
	.S_AXI_WREADY_OUT, .S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN,
	.S_AXI_ARADDR_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT,
	.S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .SLEEP_DONE_IN, .SLEEP_REQ_OUT,
	.SMI_OUT, .PLL_POWER_OUT, .IR_CLK_SEL_PLL_OUT);

// ==== testbench/asw_pwr_model.sv ====
`timescale 1ns/1ps
module asw_pwr_model #(
	parameter int DLY = 5
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic req_in,
	output logic      done_out
);
	logic [7:0] cnt_r;
	// Power control answers after a delay, holds done until request drops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= 8'h00;
			done_out <= 1'b0;
		end else if (!req_in) begin
			cnt_r <= 8'h00;
			done_out <= 1'b0;
		end else if (cnt_r == DLY) done_out <= 1'b1;
		else cnt_r <= cnt_r + 8'h01;
	end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic clk, rst_n, awv, wv, bready, arv, rready, pon_n;
	logic awr, wr_r, bv, arr, rv, sreq, smi, wsts, pll, irsel;
	logic [7:0] awaddr, araddr, wev;
	logic [31:0] wdata, rdata, g;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [2:0] stype;
	logic done;
	int err_total, checks, cyc, i;
	logic [7:0] ta[5] = '{8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'h40};
	logic [7:0] td[5] = '{8'hFF, 8'h7C, 8'h81, 8'h02, 8'h55};
	logic [7:0] te[5] = '{8'h83, 8'h00, 8'h81, 8'h02, 8'h00};
	logic [1:0] tr[5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2};

	asw_top dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWADDR_IN(awaddr),
		.S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wdata),
		.S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_r),
		.S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bready),
		.S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arv),
		.S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdata),
		.S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rready),
		.POWER_ON_REQUEST_N_IN(pon_n), .WAKE_EVENT_IN(wev),
		.SLEEP_DONE_IN(done), .SLEEP_REQ_OUT(sreq), .SLEEP_TYPE_OUT(stype),
		.SMI_OUT(smi), .WAKE_STATUS_OUT(wsts), .PLL_POWER_OUT(pll),
		.IR_CLK_SEL_PLL_OUT(irsel));
	asw_pwr_model #(.DLY(5)) u_pwr (.clk_in(clk), .rst_n_in(rst_n),
		.req_in(sreq), .done_out(done));

	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Handshakes judged at the rising edge, before the design updates
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad;
		logic dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata  <= d;
		awv    <= 1'b1;
		wv     <= 1'b1;
		bready <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge clk);
			if (!ad && awr) begin
				awv <= 1'b0;
				ad = 1'b1;
			end
			if (!dd && wr_r) begin
				wv <= 1'b0;
				dd = 1'b1;
			end
		end
		do @(posedge clk); while (bv !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	// Read data taken at the edge that sees valid with ready
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arv    <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk); while (rv !== 1'b1);
		g = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	initial begin
		{awv, wv, bready, arv, rready, rst_n} = 6'h00;
		{awaddr, araddr, wev, wdata} = 56'h0;
		wstrb = 4'hF;
		pon_n = 1'b1;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'hF0);
		chk(g, 32'h0);
		chk(pll, 1'b0);
		chk(irsel, 1'b0);
		// Configuration writes, reserved bits and an unmapped place
		for (i = 0; i < 5; i++) begin
			wr(ta[i], td[i]);
			chk(r, tr[i]);
			rd(ta[i]);
			chk(g, te[i]);
			chk(r, tr[i]);
			if (i < 4) begin
				chk(pll, te[i][7]);
				chk(irsel, te[i][7]);
			end
		end
		// Plain sleep with type five
		wr(8'hF0, 32'h0);
		wr(8'h00, 32'h0B);
		for (i = 0; i < 20 && sreq !== 1'b1; i++) begin
			@(posedge clk);
		end
		chk(sreq, 1'b1);
		chk(stype, 3'h5);
		chk(smi, 1'b0);
		rd(8'h04);
		chk(g[0], 1'b1);
		chk(g[2], 1'b1);
		for (i = 0; i < 30 && sreq !== 1'b0; i++) begin
			@(posedge clk);
		end
		chk(sreq, 1'b0);
		wr(8'h04, 32'h1);
		// Redirected sleep raises smi only; redirect clear hides it
		wr(8'hF0, 32'h1);
		wr(8'h00, 32'h1);
		wt(4);
		chk(sreq, 1'b0);
		chk(smi, 1'b1);
		wr(8'hF0, 32'h0);
		chk(smi, 1'b0);
		rd(8'h04);
		chk(g[0], 1'b1);
		wr(8'h04, 32'h1);
		wt(1);
		chk(smi, 1'b0);
		rd(8'h04);
		chk(g[0], 1'b0);
		// Wake source: power-on request only
		wr(8'hF0, 32'h0);
		wr(8'h08, 32'hFF);
		@(posedge clk) wev <= 8'h01;
		wt(4);
		chk(wsts, 1'b0);
		@(posedge clk) pon_n <= 1'b0;
		wt(4);
		chk(wsts, 1'b1);
		@(posedge clk) pon_n <= 1'b1;
		wr(8'h04, 32'h2);
		wt(1);
		chk(wsts, 1'b0);
		// Wake source: enabled events too, disabled one ignored
		wr(8'hF0, 32'h2);
		wr(8'h08, 32'h1);
		@(posedge clk) wev <= 8'h02;
		wt(4);
		chk(wsts, 1'b0);
		@(posedge clk) wev <= 8'h03;
		wt(4);
		chk(wsts, 1'b1);
		// Lane zero off: write answered but configuration kept
		@(posedge clk) wstrb <= 4'hE;
		wr(8'hF0, 32'h81);
		chk(r, 2'h0);
		rd(8'hF0);
		chk(g, 32'h2);
		chk(pll, 1'b0);
		@(posedge clk) wstrb <= 4'hF;
		// Reset in mid-run returns flags and configuration to default
		@(posedge clk) rst_n <= 1'b0;
		wt(2);
		@(posedge clk) rst_n <= 1'b1;
		chk(wsts, 1'b0);
		chk(sreq, 1'b0);
		rd(8'hF0);
		chk(g, 32'h0);
		end_sim();
	end
endmodule
